// ===== hw/ssf_defs.svh
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

// byte addresses on the apb side
`define SSF_ADDR_DATA      12'h018
`define SSF_ADDR_STAT1     12'h01C
`define SSF_ADDR_STAT2     12'h020
`define SSF_ADDR_CTRL2     12'h024
`define SSF_ADDR_CTRL3     12'h028

// status register one bit positions
`define SSF_S1_TXE         7
`define SSF_S1_TXD         6
`define SSF_S1_RXF         5
`define SSF_S1_IDLE        4
`define SSF_S1_OVR         3
`define SSF_S1_NSE         2
`define SSF_S1_FRM         1
`define SSF_S1_PAR         0

// status register two bit positions
`define SSF_S2_BRK         1
`define SSF_S2_RXA         0

// control register two bit positions
`define SSF_C2_TXEIE       7
`define SSF_C2_TXDIE       6
`define SSF_C2_RXFIE       5
`define SSF_C2_IDLEIE      4

// control register three bit positions
`define SSF_C3_NINTH       7
`define SSF_C3_OVRIE       3
`define SSF_C3_NSEIE       2
`define SSF_C3_FRMIE       1
`define SSF_C3_PARIE       0

// reset values
`define SSF_RST_CTRL       8'h00
`define SSF_RST_TXE        1'b1
`define SSF_RST_TXD        1'b1

`endif

// ===== hw/ssf_pkg.sv
package ssf_pkg;
  // index of each flag in the armed vector
  typedef enum logic [2:0] {
    SSF_F_TXE,
    SSF_F_RXF,
    SSF_F_IDLE,
    SSF_F_OVR,
    SSF_F_NSE,
    SSF_F_FRM,
    SSF_F_PAR,
    SSF_F_BRK
  } ssf_flag_t;

  typedef enum logic [1:0] {
    SSF_IDLE_WAIT_CHAR,
    SSF_IDLE_ARMED,
    SSF_IDLE_WAIT_ONES
  } ssf_idle_st_t;
endpackage

// ===== hw/ssf_status_flags.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_status_flags (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_load,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_ninth,
  input  wire logic        rx_nine_bit_mode,
  input  wire logic        rx_enable,
  input  wire logic        rx_noise,
  input  wire logic        rx_framing,
  input  wire logic        rx_parity,
  input  wire logic        rx_break,
  input  wire logic        rx_idle_char,
  input  wire logic        rx_start_seen,
  input  wire logic        rx_false_start,
  input  wire logic        rx_line_high,
  input  wire logic        tx_take,
  input  wire logic        tx_queued,
  input  wire logic        tx_busy,
  output logic      [7:0]  tx_data,
  output logic             tx_data_valid,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             err_irq
);

  // ==========================================================
  // apb decode
  // ==========================================================
  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit;
  logic       rd_stat1;
  logic       rd_stat2;
  logic       rd_data;
  logic       wr_data;

  // zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;
  assign hit      = (paddr == `SSF_ADDR_DATA)  || (paddr == `SSF_ADDR_STAT1) ||
                    (paddr == `SSF_ADDR_STAT2) || (paddr == `SSF_ADDR_CTRL2) ||
                    (paddr == `SSF_ADDR_CTRL3);
  // unmapped accesses still complete, flagged by pslverr, and change nothing
  assign pslverr  = acc & ~hit;
  assign rd_stat1 = rd & (paddr == `SSF_ADDR_STAT1);
  assign rd_stat2 = rd & (paddr == `SSF_ADDR_STAT2);
  assign rd_data  = rd & (paddr == `SSF_ADDR_DATA);
  assign wr_data  = wr & (paddr == `SSF_ADDR_DATA);

  // ==========================================================
  // control registers
  // ==========================================================
  logic [7:0] ctrl2_r;
  logic [7:0] ctrl3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_r <= `SSF_RST_CTRL;
      ctrl3_r <= `SSF_RST_CTRL;
    end else if (wr && paddr == `SSF_ADDR_CTRL2) begin
      ctrl2_r <= pwdata[7:0] & 8'hF0;
    end else if (wr && paddr == `SSF_ADDR_CTRL3) begin
      // the ninth receive bit is read-only and lives in its own flop
      ctrl3_r <= {ctrl3_r[7], 3'h0, pwdata[3:0]};
    end
  end

  // ==========================================================
  // flags
  // ==========================================================
  logic       txe_r;
  logic       txd_r;
  logic       rxf_r;
  logic       idle_r;
  logic       ovr_r;
  logic       nse_r;
  logic       frm_r;
  logic       par_r;
  logic       brk_r;
  logic       rxa_r;
  logic [7:0] armed_r;
  logic [7:0] rx_buf_r;
  logic [7:0] s1_now;
  logic       new_char;
  logic       clr_rd;
  logic       brk_ok_r;
  logic       ninth_r;
  ssf_pkg::ssf_idle_st_t idle_st_r;

  // every flag: a hardware set wins over a software clear in the same cycle
  assign s1_now = {txe_r, txd_r, rxf_r, idle_r, ovr_r, nse_r, frm_r, par_r};
  // a character is accepted only when the buffer is free
  assign new_char = (rx_load | rx_break) & ~rxf_r;
  assign clr_rd   = rd_data;

  function automatic logic armed(input ssf_pkg::ssf_flag_t f);
    armed = armed_r[f];
  endfunction

  // arm per flag
  // status two arms only break; a later status one read keeps that arm,
  // so software may read the two status registers in either order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 8'h00;
    end else if (rd_stat1) begin
      armed_r <= {brk_r & armed_r[ssf_pkg::SSF_F_BRK], par_r, frm_r, nse_r, ovr_r,
                  idle_r, rxf_r, txe_r};
    end else if (rd_stat2) begin
      armed_r[ssf_pkg::SSF_F_BRK] <= brk_r;
    end else if (rd_data) begin
      armed_r[7:1] <= 7'h00;
    end else if (wr_data) begin
      armed_r[ssf_pkg::SSF_F_TXE] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txe_r <= `SSF_RST_TXE;
    end else if (tx_take) begin
      txe_r <= 1'b1;
    end else if (wr_data && armed(ssf_pkg::SSF_F_TXE)) begin
      txe_r <= 1'b0;
    end
  end

  // done tracking
  // queueing wins over the set, so a frame being started never reads as done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_r <= `SSF_RST_TXD;
    end else if (tx_queued) begin
      txd_r <= 1'b0;
    end else if (txe_r && !tx_busy) begin
      txd_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_valid <= 1'b0;
    end else if (wr_data) begin
      tx_data_valid <= 1'b1;
    end else if (tx_take) begin
      tx_data_valid <= 1'b0;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_data) begin
      tx_data <= pwdata[7:0];
    end
  end

  // keep old contents on overrun
  // no reset: the last character stays readable across a reset
  always_ff @(posedge pclk) begin
    if (new_char) begin
      rx_buf_r <= rx_break ? 8'h00 : rx_data;
    end
  end

  // ninth bit cleared on break in nine-bit mode
  // kept through reset, like the data buffer it belongs to
  always_ff @(posedge pclk) begin
    if (new_char) begin
      ninth_r <= (rx_break && rx_nine_bit_mode) ? 1'b0 : rx_ninth;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxf_r <= 1'b0;
    end else if (new_char) begin
      rxf_r <= 1'b1;
    end else if (clr_rd && armed(ssf_pkg::SSF_F_RXF)) begin
      rxf_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_r <= 1'b0;
    end else if ((rx_load | rx_break) && rxf_r) begin
      ovr_r <= 1'b1;
    end else if (clr_rd && armed(ssf_pkg::SSF_F_OVR)) begin
      ovr_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nse_r <= 1'b0;
    end else if (rx_noise) begin
      nse_r <= 1'b1;
    end else if (clr_rd && armed(ssf_pkg::SSF_F_NSE)) begin
      nse_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_r <= 1'b0;
    end else if (rx_framing || rx_break) begin
      frm_r <= 1'b1;
    end else if (clr_rd && armed(ssf_pkg::SSF_F_FRM)) begin
      frm_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_r <= 1'b0;
    end else if (rx_parity) begin
      par_r <= 1'b1;
    end else if (clr_rd && armed(ssf_pkg::SSF_F_PAR)) begin
      par_r <= 1'b0;
    end
  end

  // break rearms only after the line returns high
  // a line held low must not report a fresh break every character time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_ok_r <= 1'b1;
    end else if (rx_break) begin
      brk_ok_r <= 1'b0;
    end else if (rx_line_high) begin
      brk_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_r <= 1'b0;
    end else if (rx_break && brk_ok_r) begin
      brk_r <= 1'b1;
    end else if (clr_rd && armed(ssf_pkg::SSF_F_BRK)) begin
      brk_r <= 1'b0;
    end
  end

  // idle qualification: a character must fill the buffer first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_st_r <= ssf_pkg::SSF_IDLE_WAIT_CHAR;
    end else begin
      case (idle_st_r)
        ssf_pkg::SSF_IDLE_WAIT_CHAR: begin
          if (new_char && !rx_break) begin
            idle_st_r <= ssf_pkg::SSF_IDLE_ARMED;
          end
        end
        ssf_pkg::SSF_IDLE_ARMED: begin
          if (rx_idle_char) begin
            idle_st_r <= ssf_pkg::SSF_IDLE_WAIT_ONES;
          end
        end
        ssf_pkg::SSF_IDLE_WAIT_ONES: begin
          if (clr_rd && armed(ssf_pkg::SSF_F_IDLE)) begin
            idle_st_r <= ssf_pkg::SSF_IDLE_WAIT_CHAR;
          end
        end
        default: idle_st_r <= ssf_pkg::SSF_IDLE_WAIT_CHAR;
      endcase
      // a disabled receiver forgets any earlier character
      if (!rx_enable) begin
        idle_st_r <= ssf_pkg::SSF_IDLE_WAIT_CHAR;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r <= 1'b0;
    end else if (rx_idle_char && idle_st_r == ssf_pkg::SSF_IDLE_ARMED) begin
      idle_r <= 1'b1;
    end else if (clr_rd && armed(ssf_pkg::SSF_F_IDLE)) begin
      idle_r <= 1'b0;
    end
  end

  // reception active
  // status only: this flag feeds no request line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxa_r <= 1'b0;
    end else if (rx_start_seen) begin
      rxa_r <= 1'b1;
    end else if (rx_false_start || rx_idle_char) begin
      rxa_r <= 1'b0;
    end
  end

  // ==========================================================
  // requests and read data
  // ==========================================================
  // levels, not pulses: each stays up until its flag is cleared
  // transmitter request
  assign tx_irq = (txe_r & ctrl2_r[`SSF_C2_TXEIE]) | (txd_r & ctrl2_r[`SSF_C2_TXDIE]);
  assign rx_irq = (rxf_r & ctrl2_r[`SSF_C2_RXFIE]) | (idle_r & ctrl2_r[`SSF_C2_IDLEIE]);
  assign err_irq = (ovr_r & ctrl3_r[`SSF_C3_OVRIE]) | (nse_r & ctrl3_r[`SSF_C3_NSEIE]) |
                   (frm_r & ctrl3_r[`SSF_C3_FRMIE]) | (par_r & ctrl3_r[`SSF_C3_PARIE]);

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `SSF_ADDR_DATA:  prdata[7:0] = rx_buf_r;
      `SSF_ADDR_STAT1: prdata[7:0] = s1_now;
      `SSF_ADDR_STAT2: prdata[1:0] = {brk_r, rxa_r};
      `SSF_ADDR_CTRL2: prdata[7:0] = ctrl2_r;
      `SSF_ADDR_CTRL3: prdata[7:0] = {ninth_r, ctrl3_r[6:0]};
      default:         prdata = 32'h0000_0000;
    endcase
  end

endmodule

// ===== sim/ssf_status_flags_properties.sv
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_status_flags_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_idle_char,
  input wire logic        rx_start_seen,
  input wire logic        rx_false_start,
  input wire logic        tx_take,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_data_valid,
  input wire logic        rx_irq,
  input wire logic        err_irq
);
  // ==========
  // access decode and reception tracking
  logic acc;
  logic rd2;
  logic mapped;
  logic rxa_r;
  assign acc = psel && penable;
  assign rd2 = acc && !pwrite && paddr == `SSF_ADDR_STAT2;
  assign mapped = paddr inside {`SSF_ADDR_DATA, `SSF_ADDR_STAT1, `SSF_ADDR_STAT2,
                                `SSF_ADDR_CTRL2, `SSF_ADDR_CTRL3};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxa_r <= 1'b0;
    end else if (rx_start_seen) begin
      rxa_r <= 1'b1;
    end else if (rx_false_start || rx_idle_char) begin
      rxa_r <= 1'b0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // properties
  ready_always_a: assert property (acc |-> pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  tx_load_a: assert property (acc && pwrite && paddr == `SSF_ADDR_DATA && !tx_take
    |=> tx_data == $past(pwdata[7:0]) && tx_data_valid)
    else $error("data write not loaded");
  take_clear_a: assert property (tx_take && !(acc && pwrite) |=> !tx_data_valid)
    else $error("transmit data still valid after take");
  rx_active_a: assert property (rd2 |-> prdata[0] == rxa_r)
    else $error("reception active flag wrong");
  rx_irq_fall_a: assert property ($fell(rx_irq) |-> $past(acc))
    else $error("receive request dropped without access");
  err_fall_a: assert property ($fell(err_irq) |-> $past(acc))
    else $error("error request dropped without access");
  cover property (acc && pslverr);
  cover property ($rose(err_irq));
  cover property (rd2 && rxa_r);
endmodule

bind ssf_status_flags ssf_status_flags_properties u_ssf_status_flags_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_idle_char(rx_idle_char), .rx_start_seen(rx_start_seen),
  .rx_false_start(rx_false_start), .tx_take(tx_take), .tx_data(tx_data),
  .tx_data_valid(tx_data_valid), .rx_irq(rx_irq), .err_irq(err_irq));

// ===== sim/ssf_line_model.sv
`timescale 1ns/1ps
// ==========
// serial engine stand-in: one strobe cycle per event
module ssf_line_model (
  input  wire logic pclk,
  output logic      rx_load,
  output logic [7:0] rx_data,
  output logic      rx_noise,
  output logic      rx_framing,
  output logic      rx_parity,
  output logic      rx_break,
  output logic      rx_idle_char,
  output logic      rx_start_seen,
  output logic      rx_false_start,
  output logic      rx_line_high,
  output logic      tx_take,
  output logic      tx_queued,
  output logic      tx_busy
);
  logic [10:0] st = 11'h000;
  assign {tx_queued, tx_take, rx_line_high, rx_false_start, rx_start_seen} = st[10:6];
  assign {rx_idle_char, rx_break, rx_parity, rx_framing, rx_noise, rx_load} = st[5:0];
  initial begin
    rx_data = 8'h00;
    tx_busy = 1'b0;
  end
  task automatic put(input logic [7:0] d, input logic [10:0] m, input logic busy);
    @(posedge pclk);
    rx_data <= d;
    st <= m;
    tx_busy <= busy;
    @(posedge pclk);
    st <= 11'h000;
    // data only holds in the load cycle, so show garbage afterwards
    rx_data <= ~d;
    #1;
  endtask
endmodule

// ===== sim/async_serial_status_flags_tb.sv
`timescale 1ns/1ps
`include "ssf_defs.svh"
module async_serial_status_flags_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        rx_ninth = 1'b0;
  logic        rx_nine_bit_mode = 1'b0;
  logic        rx_enable = 1'b1;
  logic [31:0] prdata;
  logic        pready, pslverr, tx_data_valid, tx_irq, rx_irq, err_irq, se;
  logic [7:0]  tx_data, rx_data, v;
  logic        rx_load, rx_noise, rx_framing, rx_parity, rx_break, rx_idle_char;
  logic        rx_start_seen, rx_false_start, rx_line_high, tx_take, tx_queued, tx_busy;
  int          errors = 0;
  int          checked = 0;
  localparam logic [11:0] a_dt = `SSF_ADDR_DATA;
  localparam logic [11:0] a_s1 = `SSF_ADDR_STAT1;
  localparam logic [11:0] a_s2 = `SSF_ADDR_STAT2;
  localparam logic [11:0] a_c2 = `SSF_ADDR_CTRL2;
  localparam logic [11:0] a_c3 = `SSF_ADDR_CTRL3;
  ssf_status_flags u_ssf_status_flags (.*);
  ssf_line_model u_ssf_line_model (.*);
  always #2.5 pclk = ~pclk;
  // ==========
  // bus and check helpers
  task automatic close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ci(input string nm, input logic e, input logic g);
    chk(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    v = prdata[7:0];
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    if (n == 16) begin
      errors++;
      close_out();
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, v & m);
  endtask
  task automatic rst;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // ==========
  // scenarios
  initial begin
    int i;
    rst();
    bus(1'b1, a_dt, 8'h5A);
    rc(a_s1, 8'hFF, 8'hC0, "status1");
    rc(a_s2, 8'hFF, 8'h00, "status2");
    rc(a_c2, 8'hFF, 8'h00, "ctrl2");
    rc(a_c3, 8'h0F, 8'h00, "ctrl3");
    rc(12'h030, 8'hFF, 8'h00, "unmapped");
    ci("slverr", 1'b1, se);
    ci("tx_irq", 1'b0, tx_irq);
    bus(1'b1, a_c2, 8'hF0);
    ci("tx_irq", 1'b1, tx_irq);
    bus(1'b1, a_dt, 8'hA5);
    chk("tx_data", 8'hA5, tx_data);
    rc(a_s1, 8'h80, 8'h00, "txe_clr");
    u_ssf_line_model.put(8'h00, 11'h600, 1'b1);
    ci("tx_valid", 1'b0, tx_data_valid);
    rc(a_s1, 8'hC0, 8'h80, "tx_sent");
    u_ssf_line_model.put(8'h00, 11'h000, 1'b0);
    rc(a_s1, 8'hC0, 8'hC0, "tx_done");
    u_ssf_line_model.put(8'h3C, 11'h001, 1'b0);
    rc(a_s1, 8'h3F, 8'h20, "rx_full");
    ci("rx_irq", 1'b1, rx_irq);
    u_ssf_line_model.put(8'h77, 11'h001, 1'b0);
    bus(1'b1, a_c3, 8'h08);
    ci("err_irq", 1'b1, err_irq);
    rc(a_s1, 8'h3F, 8'h28, "overrun");
    rc(a_dt, 8'hFF, 8'h3C, "rx_kept");
    rc(a_s1, 8'h3F, 8'h00, "rx_clr");
    ci("rx_irq", 1'b0, rx_irq);
    u_ssf_line_model.put(8'h11, 11'h001, 1'b0);
    rc(a_s1, 8'h3F, 8'h20, "rx_one");
    u_ssf_line_model.put(8'h22, 11'h001, 1'b0);
    rc(a_dt, 8'hFF, 8'h11, "rx_first");
    rc(a_s1, 8'h3F, 8'h08, "ovr_kept");
    bus(1'b0, a_dt, 8'h00);
    rc(a_s1, 8'h3F, 8'h00, "ovr_clr");
    u_ssf_line_model.put(8'h44, 11'h001, 1'b0);
    u_ssf_line_model.put(8'h00, 11'h020, 1'b0);
    rc(a_s1, 8'h30, 8'h30, "idle_set");
    bus(1'b0, a_dt, 8'h00);
    rc(a_s1, 8'h30, 8'h00, "idle_clr");
    u_ssf_line_model.put(8'h00, 11'h020, 1'b0);
    rc(a_s1, 8'h10, 8'h00, "idle_early");
    u_ssf_line_model.put(8'h55, 11'h00F, 1'b0);
    rc(a_s1, 8'h2F, 8'h27, "rx_faults");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, a_c3, 8'(1 << i));
      ci("err_irq", i < 3, err_irq);
    end
    rc(a_dt, 8'hFF, 8'h55, "rx_data");
    rc(a_s1, 8'h2F, 8'h00, "faults_clr");
    u_ssf_line_model.put(8'h00, 11'h010, 1'b0);
    rc(a_s1, 8'h23, 8'h22, "brk_s1");
    rc(a_s2, 8'h02, 8'h02, "brk_set");
    bus(1'b0, a_dt, 8'h00);
    rc(a_s2, 8'h02, 8'h00, "brk_clr");
    u_ssf_line_model.put(8'h00, 11'h010, 1'b0);
    rc(a_s2, 8'h02, 8'h00, "brk_hold");
    u_ssf_line_model.put(8'h00, 11'h100, 1'b0);
    u_ssf_line_model.put(8'h00, 11'h010, 1'b0);
    rc(a_s2, 8'h02, 8'h02, "brk_again");
    bus(1'b0, a_s1, 8'h00);
    bus(1'b0, a_dt, 8'h00);
    u_ssf_line_model.put(8'h00, 11'h040, 1'b0);
    rc(a_s2, 8'h01, 8'h01, "rxa_set");
    u_ssf_line_model.put(8'h00, 11'h080, 1'b0);
    rc(a_s2, 8'h01, 8'h00, "rxa_false");
    u_ssf_line_model.put(8'h00, 11'h040, 1'b0);
    u_ssf_line_model.put(8'h00, 11'h020, 1'b0);
    rc(a_s2, 8'h01, 8'h00, "rxa_idle");
    @(posedge pclk);
    rx_ninth <= 1'b1;
    rx_nine_bit_mode <= 1'b1;
    u_ssf_line_model.put(8'h12, 11'h001, 1'b0);
    rc(a_c3, 8'h80, 8'h80, "ninth_set");
    rc(a_s1, 8'h30, 8'h30, "idle_rxf");
    bus(1'b0, a_dt, 8'h00);
    u_ssf_line_model.put(8'h00, 11'h010, 1'b0);
    rc(a_c3, 8'h80, 8'h00, "ninth_brk");
    bus(1'b0, a_s1, 8'h00);
    bus(1'b0, a_dt, 8'h00);
    u_ssf_line_model.put(8'h34, 11'h001, 1'b0);
    @(posedge pclk);
    rx_enable <= 1'b0;
    @(posedge pclk);
    rx_enable <= 1'b1;
    u_ssf_line_model.put(8'h00, 11'h020, 1'b0);
    rc(a_s1, 8'h30, 8'h20, "idle_reen");
    bus(1'b0, a_dt, 8'h00);
    u_ssf_line_model.put(8'h66, 11'h001, 1'b0);
    rst();
    rc(a_dt, 8'hFF, 8'h66, "rx_after_rst");
    chk("tx_after_rst", 8'hA5, tx_data);
    rc(a_s1, 8'hFF, 8'hC0, "s1_after_rst");
    rc(a_c3, 8'hFF, 8'h80, "c3_after_rst");
    close_out();
  end
endmodule
